/* File: core/evt_host.sv */
// Host controller that launches event timing on the measurement device,
// polls its interrupt pin and fetches the results the status flags announce.
// Assumes software on a single-cycle register port and a serial device link.
//
// Function
// - Start only once configuration is complete and saved to non-volatile storage.
// - Flight-time and temperature sequences should be programmed equally long.
// - Start a mode by sending that mode's own start command.
// - While a mode runs, sample the interrupt pin every 250 ms.
// - On asserted interrupt, read status register and pick data by flags.
// - Flight measurement flag: read up, down, difference, then clock.
// - Temperature measurement flag: read temperature ports, then clock.
// - Flight sequence flag: read averaged difference and range, then clock.
// - Temperature sequence flag: read averaged temperature ports, then clock.
// - Abandoning a running mode sends halt and stops sampling.
// - Keep sampling until mode finishes, halt is sent or servicing stops.
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
module evt_host
  import evt_host_pkg::*;
#(
  parameter int unsigned POLL_CNT = POLL_CYCLES,
  parameter int SCLK_DIV = SPI_DIV
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  output logic irq_o,
  input wire logic int_n_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  host_state_t state, next_state;
  ctrl_t ctrl, next_ctrl;
  logic [EVT_W-1:0] evt, next_evt, evt_set;
  logic [EVT_W-1:0] mask, next_mask;
  logic [15:0] isr, next_isr;
  logic [15:0] rdata, next_rdata;
  logic [31:0] timer, next_timer;
  logic [3:0] pend, next_pend;
  logic [1:0] seen, next_seen;
  logic [1:0] cur, next_cur;
  logic [2:0] idx, next_idx;
  logic inflight, next_inflight;
  logic halt_pend, next_halt_pend;
  logic [15:0] res [4][RES_DEPTH];
  logic start_cmd, halt_cmd, tick, needs_xfer, spi_go, spi_busy, spi_done;
  logic [15:0] spi_rx;
  spi_req_t req;

  function automatic logic [1:0] first_flag(input logic [3:0] p);
    if (p[0]) return 2'h0;
    if (p[1]) return 2'h1;
    if (p[2]) return 2'h2;
    return 2'h3;
  endfunction : first_flag

  ////////////////////////////////////////////////////////////////////////////
  // Register port

  assign start_cmd = wr_i && (addr_i == REG_CTRL) && wdata_i[CTRL_START_BIT];
  assign halt_cmd = wr_i && (addr_i == REG_CTRL) && wdata_i[CTRL_HALT_BIT];

  always_comb begin
    next_ctrl = ctrl;
    next_mask = mask;
    next_rdata = 16'h0000;
    if (wr_i && addr_i == REG_CTRL) begin
      next_ctrl.cfg_saved = wdata_i[CTRL_CFG_BIT];
      next_ctrl.cont = wdata_i[CTRL_CONT_BIT];
      next_ctrl.mode = wdata_i[CTRL_MODE_LSB +: 3];
    end
    if (wr_i && addr_i == REG_MASK) begin
      next_mask = wdata_i[EVT_W-1:0];
    end
    // Unmapped addresses read as zero
    if (rd_i) begin
      if (addr_i[7]) begin
        next_rdata = (addr_i[4:2] < 3'(RES_DEPTH)) ? res[addr_i[6:5]][addr_i[4:2]] : 16'h0000;
      end else begin
        case (addr_i)
          REG_CTRL: next_rdata = 16'({ctrl.mode, ctrl.cont, ctrl.cfg_saved, 2'b00});
          REG_EVENT: next_rdata = 16'(evt);
          REG_MASK: next_rdata = 16'(mask);
          REG_ISR: next_rdata = isr;
          REG_STATE: next_rdata = 16'({halt_pend, state != ST_IDLE});
          default: next_rdata = 16'h0000;
        endcase
      end
    end
    // Write-one-to-clear; a same-cycle hardware set wins
    next_evt = evt;
    if (wr_i && addr_i == REG_EVENT) begin
      next_evt = evt & ~wdata_i[EVT_W-1:0];
    end
    next_evt = next_evt | evt_set;
  end

  assign irq_o = |(evt & mask);
  assign rdata_o = rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  assign tick = (timer == POLL_CNT - 1);
  assign needs_xfer = (state == ST_START) || (state == ST_ISR) ||
                      (state == ST_FETCH) || (state == ST_HALT);
  assign spi_go = needs_xfer && !inflight && !spi_busy;

  always_comb begin
    case (state)
      ST_START: req = '{op: start_opcode(ctrl.mode), cmd_only: 1'b1};
      ST_HALT: req = '{op: OP_HALT, cmd_only: 1'b1};
      ST_FETCH: req = '{op: read_opcode(cur, idx), cmd_only: 1'b0};
      default: req = '{op: OP_READ_ISR, cmd_only: 1'b0};
    endcase
  end

  always_comb begin
    next_state = state;
    next_timer = timer;
    next_isr = isr;
    next_pend = pend;
    next_seen = seen;
    next_cur = cur;
    next_idx = idx;
    next_inflight = spi_go ? 1'b1 : (spi_done ? 1'b0 : inflight);
    next_halt_pend = halt_pend || (halt_cmd && state != ST_IDLE && state != ST_HALT);
    evt_set = '0;
    case (state)
      ST_IDLE: begin
        if (start_cmd) begin
          if (ctrl.cfg_saved) begin
            next_state = ST_START;
          end else begin
            evt_set[EVT_REFUSED_BIT] = 1'b1;
          end
        end
      end
      ST_START: begin
        if (spi_done) begin
          next_state = ST_POLL;
          next_timer = '0;
          next_seen = 2'b00;
        end
      end
      ST_POLL: begin
        next_timer = tick ? '0 : timer + 32'h0000_0001;
        if (halt_pend || halt_cmd) begin
          next_state = ST_HALT;
        end else if (tick && !int_n_i) begin
          next_state = ST_ISR;
        end
      end
      ST_ISR: begin
        if (spi_done) begin
          next_isr = spi_rx;
          next_pend = {spi_rx[ISR_TEMP_SEQ_BIT], spi_rx[ISR_FLIGHT_SEQ_BIT],
                       spi_rx[ISR_TEMP_MEAS_BIT], spi_rx[ISR_FLIGHT_MEAS_BIT]};
          next_cur = first_flag(next_pend);
          next_idx = 3'h0;
          next_state = (next_pend == 4'h0) ? ST_POLL : ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (spi_done) begin
          next_idx = idx + 3'h1;
          if (idx == read_count(cur) - 3'h1) begin
            evt_set[cur] = 1'b1;
            next_pend[cur] = 1'b0;
            if (cur == 2'(FLAG_FLIGHT_SEQ)) next_seen[0] = 1'b1;
            if (cur == 2'(FLAG_TEMP_SEQ)) next_seen[1] = 1'b1;
            next_cur = first_flag(next_pend);
            next_idx = 3'h0;
            if (next_pend == 4'h0) begin
              if (!ctrl.cont && next_seen == 2'b11) begin
                next_state = ST_IDLE;
                evt_set[EVT_FINISHED_BIT] = 1'b1;
              end else begin
                next_state = ST_POLL;
              end
            end
          end
        end
      end
      ST_HALT: begin
        next_halt_pend = 1'b0;
        if (spi_done) begin
          next_state = ST_IDLE;
          evt_set[EVT_HALTED_BIT] = 1'b1;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      ctrl <= ctrl_t'(CTRL_RESET[CTRL_CFG_BIT +: 5]);
      evt <= '0;
      mask <= '0;
      isr <= 16'h0000;
      rdata <= 16'h0000;
      timer <= '0;
      pend <= 4'h0;
      seen <= 2'b00;
      cur <= 2'h0;
      idx <= 3'h0;
      inflight <= 1'b0;
      halt_pend <= 1'b0;
    end else begin
      state <= next_state;
      ctrl <= next_ctrl;
      evt <= next_evt;
      mask <= next_mask;
      isr <= next_isr;
      rdata <= next_rdata;
      timer <= next_timer;
      pend <= next_pend;
      seen <= next_seen;
      cur <= next_cur;
      idx <= next_idx;
      inflight <= next_inflight;
      halt_pend <= next_halt_pend;
    end
  end

  // Result store; not reset, software only reads words whose event fired
  always_ff @(posedge ref_clk_i) begin
    if (state == ST_FETCH && spi_done) begin
      res[cur][idx] <= spi_rx;
    end
  end

  spi_xfer #(.DIV(SCLK_DIV)) u_spi (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .go_i(spi_go),
    .req_i(req),
    .busy_o(spi_busy),
    .done_o(spi_done),
    .rx_o(spi_rx),
    .sclk_o(sclk_o),
    .cs_n_o(cs_n_o),
    .mosi_o(mosi_o),
    .miso_i(miso_i)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  chk_start_needs_cfg: assert property (
    state == ST_IDLE && start_cmd && !ctrl.cfg_saved |=> state == ST_IDLE && evt[EVT_REFUSED_BIT])
    else $error("start accepted without saved configuration");

  chk_start_opcode: assert property (
    state == ST_START && spi_go |-> req.op == start_opcode(ctrl.mode) && req.cmd_only)
    else $error("wrong start command for mode");

  chk_poll_interval: assert property (
    state == ST_POLL && !tick && !halt_pend && !halt_cmd |=> state == ST_POLL)
    else $error("poll left before the interval elapsed");

  chk_isr_read: assert property (
    state == ST_ISR && spi_go |-> req.op == OP_READ_ISR ##1 state == ST_ISR)
    else $error("status read not issued on interrupt");

  chk_fetch_opcode: assert property (
    state == ST_FETCH && spi_go |-> req.op == read_opcode(cur, idx) && !req.cmd_only)
    else $error("result read uses wrong opcode");

  chk_halt_path: assert property (
    state == ST_POLL && halt_cmd |=> state == ST_HALT && spi_go && req.op == OP_HALT)
    else $error("halt not sent after abandon");

  chk_keep_sampling: assert property (
    state == ST_POLL && tick && int_n_i && !halt_pend && !halt_cmd |=> state == ST_POLL)
    else $error("sampling stopped with nothing pending");

  chk_low_active: assert property (
    state == ST_POLL && tick && !int_n_i && !halt_pend && !halt_cmd |=> state == ST_ISR)
    else $error("low interrupt level not serviced");

endmodule : evt_host

/* File: pkg/evt_host_pkg.sv */
// Constants, types and lookup functions for the event-timing host controller.
// Assumes a 40 MHz single clock and a device reached by a byte-opcode serial port.
package evt_host_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned POLL_PERIOD_MS = 250;
  localparam int unsigned POLL_CYCLES = CLK_HZ / 1000 * POLL_PERIOD_MS;
  localparam int unsigned SPI_DIV = 4;

  // Host register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_EVENT = 8'h04;
  localparam logic [7:0] REG_MASK = 8'h08;
  localparam logic [7:0] REG_ISR = 8'h0C;
  localparam logic [7:0] REG_STATE = 8'h10;
  // Results live at 0x80 + (flag*8 + index)*4
  localparam logic [7:0] REG_RESULT_BASE = 8'h80;

  // Control register fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_HALT_BIT = 1;
  localparam int CTRL_CFG_BIT = 2;
  localparam int CTRL_CONT_BIT = 3;
  localparam int CTRL_MODE_LSB = 4;
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // Event register bits 0..3 follow the flag order below
  localparam int EVT_FINISHED_BIT = 4;
  localparam int EVT_HALTED_BIT = 5;
  localparam int EVT_REFUSED_BIT = 6;
  localparam int EVT_W = 7;

  // Flag order used everywhere: flight meas, temp meas, flight seq, temp seq
  localparam int FLAG_FLIGHT_MEAS = 0;
  localparam int FLAG_TEMP_MEAS = 1;
  localparam int FLAG_FLIGHT_SEQ = 2;
  localparam int FLAG_TEMP_SEQ = 3;

  // Device interrupt status bit positions
  localparam int ISR_FLIGHT_MEAS_BIT = 12;
  localparam int ISR_TEMP_MEAS_BIT = 11;
  localparam int ISR_FLIGHT_SEQ_BIT = 10;
  localparam int ISR_TEMP_SEQ_BIT = 9;

  // Device opcodes
  localparam logic [7:0] OP_START_BASE = 8'h02;
  localparam logic [7:0] OP_HALT = 8'h05;
  localparam logic [7:0] OP_READ_ISR = 8'hFE;
  localparam logic [7:0] OP_READ_UP_AVG = 8'hC4;
  localparam logic [7:0] OP_READ_DOWN_AVG = 8'hCC;
  localparam logic [7:0] OP_READ_DIFF = 8'hD4;
  localparam logic [7:0] OP_READ_DIFF_AVG = 8'hDC;
  localparam logic [7:0] OP_READ_RANGE = 8'hE0;
  localparam logic [7:0] OP_READ_TEMP_PORT = 8'hE7;
  localparam logic [7:0] OP_READ_TEMP_AVG = 8'hEB;
  localparam logic [7:0] OP_READ_RTC = 8'hB0;

  localparam int RES_DEPTH = 6;

  typedef enum {
    ST_IDLE,
    ST_START,
    ST_POLL,
    ST_ISR,
    ST_FETCH,
    ST_HALT
  } host_state_t;

  typedef struct packed {
    logic [7:0] op;
    logic cmd_only;
  } spi_req_t;

  typedef struct packed {
    logic [2:0] mode;
    logic cont;
    logic cfg_saved;
  } ctrl_t;

  function automatic logic [7:0] start_opcode(input logic [2:0] mode);
    return OP_START_BASE + {5'h00, mode};
  endfunction : start_opcode

  // Words fetched for each flag; the clock value always comes last, two words
  function automatic logic [2:0] read_count(input logic [1:0] flag);
    case (flag)
      2'h0: return 3'h5;
      2'h1: return 3'h6;
      2'h2: return 3'h4;
      default: return 3'h6;
    endcase
  endfunction : read_count

  function automatic logic [7:0] read_opcode(input logic [1:0] flag, input logic [2:0] idx);
    logic [2:0] data_words;
    data_words = read_count(flag) - 3'h2;
    if (idx >= data_words) begin
      return OP_READ_RTC + {7'h00, idx[0] ^ data_words[0]};
    end
    case (flag)
      2'h0: return (idx == 3'h0) ? OP_READ_UP_AVG :
                   (idx == 3'h1) ? OP_READ_DOWN_AVG : OP_READ_DIFF;
      2'h1: return OP_READ_TEMP_PORT + {5'h00, idx};
      2'h2: return (idx == 3'h0) ? OP_READ_DIFF_AVG : OP_READ_RANGE;
      default: return OP_READ_TEMP_AVG + {5'h00, idx};
    endcase
  endfunction : read_opcode

endpackage : evt_host_pkg

/* File: core/spi_xfer.sv */
// Serial port engine: one opcode byte, then optionally one 16-bit word read back.
// Assumes clock-idle-low mode 0 device; miso is synchronous to ref_clk_i.
`timescale 1ns/1ps
module spi_xfer
  import evt_host_pkg::*;
#(
  parameter int DIV = SPI_DIV
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire spi_req_t req_i,
  output logic busy_o,
  output logic done_o,
  output logic [15:0] rx_o,
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i
);

  typedef enum {
    SP_IDLE,
    SP_RUN
  } spi_state_t;

  spi_state_t state, next_state;
  logic [7:0] div_cnt, next_div_cnt;
  logic [4:0] bits, next_bits;
  logic [23:0] shreg, next_shreg;
  logic [15:0] rx, next_rx;
  logic sclk, next_sclk;
  logic cs_n, next_cs_n;
  logic done, next_done;
  logic en;

  // Divider enable sets the half period of the serial clock
  assign en = (div_cnt == 8'(DIV - 1));

  always_comb begin
    next_state = state;
    next_div_cnt = div_cnt;
    next_bits = bits;
    next_shreg = shreg;
    next_rx = rx;
    next_sclk = sclk;
    next_cs_n = cs_n;
    next_done = 1'b0;
    case (state)
      SP_IDLE: begin
        if (go_i) begin
          next_state = SP_RUN;
          next_shreg = {req_i.op, 16'h0000};
          next_bits = req_i.cmd_only ? 5'h08 : 5'h18;
          next_cs_n = 1'b0;
          next_div_cnt = 8'h00;
        end
      end
      SP_RUN: begin
        next_div_cnt = en ? 8'h00 : div_cnt + 8'h01;
        if (en) begin
          if (!sclk) begin
            next_sclk = 1'b1;
            next_rx = {rx[14:0], miso_i};
          end else begin
            next_sclk = 1'b0;
            next_shreg = {shreg[22:0], 1'b0};
            next_bits = bits - 5'h01;
            if (bits == 5'h01) begin
              next_state = SP_IDLE;
              next_cs_n = 1'b1;
              next_done = 1'b1;
            end
          end
        end
      end
      default: next_state = SP_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state <= SP_IDLE;
      div_cnt <= 8'h00;
      bits <= 5'h00;
      shreg <= 24'h00_0000;
      rx <= 16'h0000;
      sclk <= 1'b0;
      cs_n <= 1'b1;
      done <= 1'b0;
    end else begin
      state <= next_state;
      div_cnt <= next_div_cnt;
      bits <= next_bits;
      shreg <= next_shreg;
      rx <= next_rx;
      sclk <= next_sclk;
      cs_n <= next_cs_n;
      done <= next_done;
    end
  end

  assign busy_o = (state != SP_IDLE);
  assign done_o = done;
  assign rx_o = rx;
  assign sclk_o = sclk;
  assign cs_n_o = cs_n;
  assign mosi_o = shreg[23];

endmodule : spi_xfer

/* File: testbench/evt_dev_model.sv */
// Behavioural measurement device on the serial link, facing the host controller.
// Assumes mode 0 framing and that all host outputs are synchronous to ref_clk_i.
`timescale 1ns/1ps
module evt_dev_model
  import evt_host_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic int_n_o,
  input wire logic [3:0] post_i,
  output logic running_o,
  output logic [7:0] start_op_o,
  output logic [7:0] halts_o,
  output logic [7:0] xfers_o
);
  logic sclk_q;
  logic [4:0] nbits;
  logic [7:0] op;
  logic [15:0] isr;
  logic [15:0] shreg;
  logic [15:0] data;

  // Status word for its own opcode, else a word derived from the opcode
  always_comb begin
    data = (nbits == 5'd8) ? ((op == OP_READ_ISR) ? isr : {op, ~op}) : shreg;
  end

  // pin low while a flag pends
  assign int_n_o = ~(|isr);

  always_ff @(posedge ref_clk_i) begin
    sclk_q <= sclk_i;
    if (rst_i) begin
      running_o <= 1'b0;
      nbits <= 5'd0;
      op <= 8'h00;
      isr <= 16'h0000;
      shreg <= 16'h0000;
      miso_o <= 1'b0;
      start_op_o <= 8'h00;
      halts_o <= 8'h00;
      xfers_o <= 8'h00;
    end else begin
      if (cs_n_i) begin
        // Deselected: toggle so no stale bit can be mistaken for data
        miso_o <= ~miso_o;
        nbits <= 5'd0;
        if (nbits != 5'd0) begin
          xfers_o <= xfers_o + 8'h01;
          if (nbits == 5'd8 && op == OP_HALT) begin
            running_o <= 1'b0;
            halts_o <= halts_o + 8'h01;
          end else if (nbits == 5'd8) begin
            running_o <= 1'b1;
            start_op_o <= op;
          end else if (op == OP_READ_ISR) begin
            isr <= 16'h0000;
          end
        end
      end else if (sclk_i && !sclk_q) begin
        op <= (nbits < 5'd8) ? {op[6:0], mosi_i} : op;
        nbits <= nbits + 5'd1;
      end else if (!sclk_i && sclk_q && nbits >= 5'd8) begin
        miso_o <= data[15];
        shreg <= {data[14:0], 1'b0};
      end
      if (post_i[0]) isr[ISR_FLIGHT_MEAS_BIT] <= 1'b1;
      if (post_i[1]) isr[ISR_TEMP_MEAS_BIT] <= 1'b1;
      if (post_i[2]) isr[ISR_FLIGHT_SEQ_BIT] <= 1'b1;
      if (post_i[3]) isr[ISR_TEMP_SEQ_BIT] <= 1'b1;
    end
  end
endmodule : evt_dev_model

/* File: testbench/event_timing_interrupt_service_tb_top.sv */
// Self-checking bench for the event-timing host: register port tasks and scenarios.
// Assumes the device model on the serial pins and shortened poll and clock counts.
`timescale 1ns/1ps
module event_timing_interrupt_service_tb_top;
  import evt_host_pkg::*;
  localparam int unsigned PC = 50;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [15:0] rdata_o;
  logic irq_o;
  logic int_n_i;
  logic sclk_o;
  logic cs_n_o;
  logic mosi_o;
  logic miso_i;
  logic [3:0] post = 4'h0;
  logic running;
  logic [7:0] start_op;
  logic [7:0] halts;
  logic [7:0] xfers;
  logic [15:0] v;
  int n_mismatch = 0;
  int checks_done = 0;

  always #12.5 ref_clk_i = ~ref_clk_i;

  evt_host #(.POLL_CNT(PC), .SCLK_DIV(2)) uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .irq_o(irq_o), .int_n_i(int_n_i), .sclk_o(sclk_o), .cs_n_o(cs_n_o), .mosi_o(mosi_o),
    .miso_i(miso_i));

  evt_dev_model dev (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .sclk_i(sclk_o),
    .cs_n_i(cs_n_o), .mosi_i(mosi_o), .miso_o(miso_i), .int_n_o(int_n_i), .post_i(post),
    .running_o(running), .start_op_o(start_op), .halts_o(halts), .xfers_o(xfers));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    // Let the write settle before any following look at outputs
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd

  // Bounded poll of a register until the masked bits read as wanted
  task automatic wait_reg(input logic [7:0] a, input logic [15:0] m, input logic [15:0] w);
    int i;
    for (i = 0; i < 3000; i++) begin
      rd(a, v);
      if ((v & m) === w) return;
    end
    n_mismatch++;
    stop_test();
  endtask : wait_reg

  // Raise flags, then the host must select the device within PC + 4 clock cycles
  task automatic post_flags(input logic [3:0] f);
    int n;
    @(posedge ref_clk_i);
    post <= f;
    @(posedge ref_clk_i);
    post <= 4'h0;
    n = 0;
    while (cs_n_o !== 1'b0 && n < PC + 4) begin
      @(posedge ref_clk_i);
      n++;
    end
    check(16'(n < PC + 4), 16'h0001);
  endtask : post_flags

  function automatic logic [7:0] exp_op(input int f, input int i);
    logic [7:0] t0 [4] = '{OP_READ_UP_AVG, OP_READ_DOWN_AVG, OP_READ_DIFF, 8'h00};
    int nd [4] = '{3, 4, 2, 4};
    if (i >= nd[f]) return OP_READ_RTC + 8'(i - nd[f]);
    case (f)
      0: return t0[i];
      1: return OP_READ_TEMP_PORT + 8'(i);
      2: return (i == 0) ? OP_READ_DIFF_AVG : OP_READ_RANGE;
      default: return OP_READ_TEMP_AVG + 8'(i);
    endcase
  endfunction : exp_op

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int f;
    int i;
    int cnt [4] = '{5, 6, 4, 6};
    logic [7:0] x;
    repeat (5) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    fork
      begin
        repeat (60000) @(posedge ref_clk_i);
        n_mismatch++;
        stop_test();
      end
    join_none
    foreach (cnt[k]) begin
      rd(8'(k * 4), v);
      check(v, 16'h0000);
    end
    rd(8'h20, v);
    check(v, 16'h0000);
    // Start without saved configuration is refused
    wr(REG_MASK, 16'h007F);
    wr(REG_CTRL, 16'h0001);
    rd(REG_EVENT, v);
    check(v, 16'h0040);
    check(16'(irq_o), 16'h0001);
    check(16'(xfers), 16'h0000);
    wr(REG_EVENT, 16'h0040);
    check(16'(irq_o), 16'h0000);
    // Single run, mode 1, every flag at once
    wr(REG_CTRL, 16'h0014);
    wr(REG_CTRL, 16'h0015);
    repeat (60) @(posedge ref_clk_i);
    check(16'(start_op), 16'h0003);
    post_flags(4'hF);
    wait_reg(REG_STATE, 16'h0001, 16'h0000);
    rd(REG_EVENT, v);
    check(v, 16'h001F);
    rd(REG_ISR, v);
    check(v, 16'h1E00);
    check(16'(xfers), 16'h0017);
    for (f = 0; f < 4; f++) begin
      for (i = 0; i < cnt[f]; i++) begin
        rd(REG_RESULT_BASE + 8'((f * 8 + i) * 4), v);
        x = exp_op(f, i);
        check(v, {x, ~x});
      end
    end
    wr(REG_EVENT, 16'h007F);
    // Continuous run, mode 2: serviced repeatedly, then halted
    wr(REG_CTRL, 16'h002C);
    wr(REG_CTRL, 16'h002D);
    repeat (60) @(posedge ref_clk_i);
    check(16'(start_op), 16'h0004);
    post_flags(4'h1);
    wait_reg(REG_EVENT, 16'h0001, 16'h0001);
    check(16'(irq_o), 16'h0001);
    post_flags(4'h2);
    wait_reg(REG_EVENT, 16'h0002, 16'h0002);
    rd(REG_STATE, v);
    check(v & 16'h0001, 16'h0001);
    wr(REG_CTRL, 16'h002E);
    wait_reg(REG_STATE, 16'h0001, 16'h0000);
    check(16'(halts), 16'h0001);
    check(16'(running), 16'h0000);
    rd(REG_EVENT, v);
    check(v, 16'h0023);
    x = xfers;
    post <= 4'h1;
    repeat (4 * PC) @(posedge ref_clk_i);
    check(16'(xfers), 16'(x));
    stop_test();
  end
endmodule : event_timing_interrupt_service_tb_top
